/* adc_conversion_sequencer.sv */
// Purpose: Control of the housekeeping_adc: single and periodic conversions, thresholds
// Assumes: AHB-Lite single word transfers; analog converter raises CONV_DONE with CONV_DATA stable
// Notes:   Zero wait state slave; event outputs are one-cycle pulses
`include "adc_seq_map.svh"
`default_nettype none
// Overview of operation
// [RULE1] Convert one of eight multiplexed channels into a 12-bit code.
// [RULE2] Converter clock runs at 2.5 MHz during conversions.
// [RULE3] Finished conversion raises an interrupt so the host can read the result. Code: periodic ones pulse THRESH_IRQ only on a crossing.
// [RULE4] Pending single request is served before periodic requests.
// [RULE5] Channel map: 0-1 external, 2 reserved, 3 supply, 4 current, 5-6 temperature, 7 test.
// [RULE6] Full range of each channel maps to codes 0 through 4095.
// [RULE7] Host writes channel first, then sets the single request.
// [RULE8] Single conversion end pulses single_done_irq and loads single result registers.
// [RULE9] Host discards first single result after a warm reset.
// [RULE10] Periodic mode converts one or two selected channels and compares thresholds.
// [RULE11] Each periodic slot has its own threshold and polarity.
// [RULE12] Control register sets interval; each slot converts only while enabled. A slot already pending in an open round still converts after its disable.
// [RULE13] Converter is powered up and down automatically around each conversion.
// [RULE14] Every periodic conversion writes its result registers.
// [RULE15] Periodic channels convert in ascending order; first result to slot a.
// [RULE16] Threshold crossing raises an interrupt and keeps the result.
// [RULE17] Newer periodic results overwrite older ones regardless of host action.
// [RULE18] Periodic conversions never stop for uncleared interrupts or unread results.
// [RULE19] Per-slot shutdown enable turns a crossing into a shutdown request.
// [RULE20] In sleep or off only channels 0-4; 5-6 also in sleep with thermal on.
// [RULE21] Calibration errors at codes 2064 and 3112 are held readable.
// [RULE22] Host corrects raw codes using offset and gain from stored errors.
// [RULE23] Results stay stable until the next conversion of the same kind.
module adc_conversion_sequencer #(
  parameter logic [23:0]     INTERVAL_BASE_CYCLES = 24'(`INTERVAL_BASE_CYC),
  parameter logic [5:0][7:0] CAL_ERRORS           = 48'h0
) (
  input  wire logic        MCLK,            // System clock, 10 MHz
  input  wire logic        RST,             // Synchronous reset, active high
  input  wire logic        HSEL,            // Slave select
  input  wire logic [31:0] HADDR,           // Byte address
  input  wire logic [1:0]  HTRANS,          // Transfer type
  input  wire logic        HWRITE,          // Write when high
  input  wire logic [2:0]  HSIZE,           // Transfer size, word only
  input  wire logic [31:0] HWDATA,          // Write data
  input  wire logic        HREADY,          // Bus ready
  output logic      [31:0] HRDATA,          // Read data
  output logic             HREADYOUT,       // Slave ready
  output logic             HRESP,           // Always OKAY
  output logic             CONV_CLK,        // Modulator clock
  output logic             CONV_POWER,      // Converter power
  output logic             CONV_START,      // Start pulse
  output logic      [2:0]  CONV_CHANNEL,    // Multiplexer select
  input  wire logic        CONV_DONE,       // Converter finished
  input  wire logic [11:0] CONV_DATA,       // Converter code
  input  wire logic        SLEEP_STATE,     // Device in sleep
  input  wire logic        OFF_STATE,       // Device off
  input  wire logic        THERMAL_EN,      // Thermal sensor enabled
  output logic             SINGLE_DONE_IRQ, // Single conversion finished
  output logic             THRESH_IRQ,      // Periodic threshold crossed
  output logic             SHUTDOWN_REQ     // Shutdown request
);

  localparam logic [7:0]  PWRUP_CYCLES = 8'(`PWRUP_CYC);
  localparam logic [1:0]  HALF_CYCLES  = 2'(`CONV_HALF_CYC);

  adc_seq_pkg::state_t    state;
  adc_seq_pkg::state_t    next_state;
  adc_seq_pkg::slot_cfg_t cfg_a;
  adc_seq_pkg::slot_cfg_t cfg_b;
  adc_seq_pkg::job_t      job;
  adc_seq_pkg::job_t      next_job;

  logic [3:0]  sync1;
  logic [3:0]  sync2;
  logic [3:0]  sync3;
  logic [3:0]  pin_stable;
  logic [3:0]  agree;
  logic        done_prev;
  logic        done_rise;
  logic        in_sleep;
  logic        in_off;
  logic        thermal_on;

  logic [2:0]  single_channel;
  logic        single_pending;
  logic [3:0]  interval_sel;
  logic [11:0] single_result;
  logic [11:0] result_a;
  logic [11:0] result_b;
  logic        crossed_a;
  logic        crossed_b;

  logic [23:0] interval_cnt;
  logic [23:0] interval_len;
  logic        tick;
  logic [1:0]  auto_pending;
  logic        round_two;
  logic        first_done;
  logic        take;
  logic        drop_single;
  logic [1:0]  drop_auto;
  logic [7:0]  wait_cnt;
  logic [1:0]  div_cnt;

  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        addr_valid;
  logic [31:0] next_rdata;
  logic        single_set;
  logic        dest_b;
  logic        crossing;
  logic [11:0] dest_thr;
  logic        dest_above;

  // Conversion allowed in the present power state
  function automatic logic ch_allowed(input logic [2:0] ch, input logic slp, input logic off, input logic th);
    logic ok;
    ok = 1'b1;
    if (slp || off)
    begin
      ok = (ch <= 3'h4) || ((ch == 3'h5 || ch == 3'h6) && slp && !off && th); // RULE20
    end
    return ok;
  endfunction : ch_allowed

  // Pin synchroniser: value moves on once stages two and three agree
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      sync1      <= 4'h0;
      sync2      <= 4'h0;
      sync3      <= 4'h0;
      pin_stable <= 4'h0;
      done_prev  <= 1'b0;
    end
    else
    begin
      sync1      <= {THERMAL_EN, OFF_STATE, SLEEP_STATE, CONV_DONE};
      sync2      <= sync1;
      sync3      <= sync2;
      pin_stable <= (agree & sync3) | (~agree & pin_stable);
      done_prev  <= pin_stable[0];
    end
  end

  assign agree      = ~(sync2 ^ sync3);
  assign done_rise  = pin_stable[0] & ~done_prev;
  assign in_sleep   = pin_stable[1];
  assign in_off     = pin_stable[2];
  assign thermal_on = pin_stable[3];

  // Periodic interval timer
  assign interval_len = INTERVAL_BASE_CYCLES * 24'({20'h0, interval_sel} + 24'h1); // RULE12
  assign tick         = (interval_cnt >= interval_len - 24'h1) && (cfg_a.enable || cfg_b.enable);

  always_ff @(posedge MCLK)
  begin
    if (RST)
      interval_cnt <= 24'h0;
    else if (tick || !(cfg_a.enable || cfg_b.enable))
      interval_cnt <= 24'h0;
    else
      interval_cnt <= interval_cnt + 24'h1; // RULE18
  end

  // Arbiter: single first, then periodic in ascending channel order
  always_comb
  begin
    next_job    = job;
    take        = 1'b0;
    drop_single = 1'b0;
    drop_auto   = 2'b00;
    if (state == adc_seq_pkg::ST_IDLE)
    begin
      if (single_pending) // RULE4
      begin
        next_job.single  = 1'b1;
        next_job.dest_b  = 1'b0;
        next_job.channel = single_channel; // RULE1
        take             = ch_allowed(single_channel, in_sleep, in_off, thermal_on);
        drop_single      = 1'b1;
      end
      else if (auto_pending != 2'b00)
      begin
        next_job.single = 1'b0;
        if (auto_pending[0] && (!auto_pending[1] || cfg_a.channel <= cfg_b.channel)) // RULE15
        begin
          next_job.channel = cfg_a.channel;
          drop_auto        = 2'b01;
          next_job.dest_b  = round_two ? first_done : 1'b0; // RULE15
        end
        else
        begin
          next_job.channel = cfg_b.channel;
          drop_auto        = 2'b10;
          next_job.dest_b  = round_two ? first_done : 1'b1;
        end
        take = ch_allowed(next_job.channel, in_sleep, in_off, thermal_on); // RULE20
      end
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      auto_pending <= 2'b00;
      round_two    <= 1'b0;
      first_done   <= 1'b0;
    end
    else if (tick && auto_pending == 2'b00)
    begin
      // Ticks inside an open round are skipped so both slots finish
      auto_pending <= {cfg_b.enable, cfg_a.enable}; // RULE10
      round_two    <= cfg_a.enable && cfg_b.enable;
      first_done   <= 1'b0;
    end
    else
    begin
      auto_pending <= auto_pending & ~drop_auto;
      if (drop_auto != 2'b00)
        first_done <= 1'b1;
    end
  end

  // Sequencer state
  always_comb
  begin
    next_state = state;
    case (state)
      adc_seq_pkg::ST_IDLE:
        if (take)
          next_state = adc_seq_pkg::ST_POWER_UP;
      adc_seq_pkg::ST_POWER_UP:
        if (wait_cnt == PWRUP_CYCLES - 8'h1)
          next_state = adc_seq_pkg::ST_CONVERT;
      adc_seq_pkg::ST_CONVERT:
        next_state = adc_seq_pkg::ST_WAIT;
      adc_seq_pkg::ST_WAIT:
        if (done_rise)
          next_state = adc_seq_pkg::ST_IDLE;
      default:
        next_state = adc_seq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      state    <= adc_seq_pkg::ST_IDLE;
      job      <= '0;
      wait_cnt <= 8'h0;
    end
    else
    begin
      state    <= next_state;
      job      <= next_job;
      wait_cnt <= (state == adc_seq_pkg::ST_POWER_UP) ? wait_cnt + 8'h1 : 8'h0;
    end
  end

  // Converter control pins
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      CONV_POWER   <= 1'b0;
      CONV_START   <= 1'b0;
      CONV_CHANNEL <= `RST_CHANNEL;
    end
    else
    begin
      CONV_POWER   <= next_state != adc_seq_pkg::ST_IDLE; // RULE13
      CONV_START   <= next_state == adc_seq_pkg::ST_CONVERT;
      CONV_CHANNEL <= next_job.channel; // RULE5
    end
  end

  // Modulator clock divider, runs only while powered
  always_ff @(posedge MCLK)
  begin
    if (RST || !CONV_POWER)
    begin
      div_cnt  <= 2'h0;
      CONV_CLK <= 1'b0;
    end
    else if (div_cnt == HALF_CYCLES - 2'h1)
    begin
      div_cnt  <= 2'h0;
      CONV_CLK <= ~CONV_CLK; // RULE2
    end
    else
      div_cnt <= div_cnt + 2'h1;
  end

  // Result capture and threshold compare
  assign dest_b     = job.dest_b;
  assign dest_thr   = dest_b ? cfg_b.threshold : cfg_a.threshold;
  assign dest_above = dest_b ? cfg_b.above : cfg_a.above;
  assign crossing   = dest_above ? (CONV_DATA > dest_thr) : (CONV_DATA < dest_thr); // RULE11

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      single_result   <= 12'h000;
      result_a        <= 12'h000;
      result_b        <= 12'h000;
      crossed_a       <= 1'b0;
      crossed_b       <= 1'b0;
      SINGLE_DONE_IRQ <= 1'b0;
      THRESH_IRQ      <= 1'b0;
      SHUTDOWN_REQ    <= 1'b0;
    end
    else
    begin
      SINGLE_DONE_IRQ <= 1'b0;
      THRESH_IRQ      <= 1'b0;
      SHUTDOWN_REQ    <= 1'b0;
      if (state == adc_seq_pkg::ST_WAIT && done_rise)
      begin
        if (job.single)
        begin
          single_result   <= CONV_DATA; // RULE8 RULE6 RULE23
          SINGLE_DONE_IRQ <= 1'b1;      // RULE3
        end
        else
        begin
          if (dest_b)
          begin
            result_b  <= CONV_DATA; // RULE14 RULE17
            crossed_b <= crossing;
          end
          else
          begin
            result_a  <= CONV_DATA; // RULE14 RULE17
            crossed_a <= crossing;
          end
          THRESH_IRQ   <= crossing; // RULE16
          SHUTDOWN_REQ <= crossing && (dest_b ? cfg_b.shutdown : cfg_a.shutdown); // RULE19
        end
      end
    end
  end

  // Bus slave: address phase capture, data phase write
  assign addr_valid = HSEL && HTRANS[1] && HREADY;
  assign single_set = wr_pend && wr_addr == `OFS_SINGLE_SELECT && HWDATA[`POS_SINGLE_REQ];

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
    else
    begin
      wr_pend   <= addr_valid && HWRITE;
      wr_addr   <= HADDR[7:0];
      HRDATA    <= (addr_valid && !HWRITE) ? next_rdata : 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  // Software request flag, the set wins over the start
  always_ff @(posedge MCLK)
  begin
    if (RST)
      single_pending <= 1'b0;
    else
      single_pending <= (single_pending && !drop_single) || single_set; // RULE7
  end

  // Configuration registers
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      single_channel <= `RST_CHANNEL;
      cfg_a          <= '{`RST_CHANNEL, `RST_THRESHOLD, 1'b1, 1'b0, 1'b0};
      cfg_b          <= '{`RST_CHANNEL, `RST_THRESHOLD, 1'b1, 1'b0, 1'b0};
      interval_sel   <= `RST_INTERVAL;
    end
    else if (wr_pend)
    begin
      case (wr_addr)
        `OFS_SINGLE_SELECT:
          single_channel <= HWDATA[2:0];
        `OFS_PERIODIC_SELECT:
        begin
          cfg_a.channel <= HWDATA[2:0];
          cfg_b.channel <= HWDATA[`POS_SLOT_B_CH +: 3];
        end
        `OFS_A_THR_LOW:
          cfg_a.threshold[7:0] <= HWDATA[7:0];
        `OFS_A_THR_HIGH:
        begin
          cfg_a.threshold[11:8] <= HWDATA[3:0];
          cfg_a.above           <= HWDATA[`POS_THR_ABOVE];
        end
        `OFS_B_THR_LOW:
          cfg_b.threshold[7:0] <= HWDATA[7:0];
        `OFS_B_THR_HIGH:
        begin
          cfg_b.threshold[11:8] <= HWDATA[3:0];
          cfg_b.above           <= HWDATA[`POS_THR_ABOVE];
        end
        `OFS_PERIODIC_CTRL:
        begin
          cfg_a.enable   <= HWDATA[`POS_A_EN]; // RULE12
          cfg_b.enable   <= HWDATA[`POS_B_EN];
          cfg_a.shutdown <= HWDATA[`POS_A_SHDN]; // RULE19
          cfg_b.shutdown <= HWDATA[`POS_B_SHDN];
          interval_sel   <= HWDATA[`POS_INTERVAL +: 4];
        end
        default:
          interval_sel <= interval_sel;
      endcase
    end
  end

  // Read multiplexer
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (HADDR[7:0])
      `OFS_SINGLE_SELECT:   next_rdata = {27'h0, single_pending, 1'b0, single_channel};
      `OFS_SINGLE_RES_LOW:  next_rdata = {24'h0, single_result[7:0]};
      `OFS_SINGLE_RES_HIGH: next_rdata = {28'h0, single_result[11:8]};
      `OFS_PERIODIC_SELECT: next_rdata = {25'h0, cfg_b.channel, 1'b0, cfg_a.channel};
      `OFS_A_THR_LOW:       next_rdata = {24'h0, cfg_a.threshold[7:0]};
      `OFS_A_THR_HIGH:      next_rdata = {24'h0, cfg_a.above, 3'h0, cfg_a.threshold[11:8]};
      `OFS_B_THR_LOW:       next_rdata = {24'h0, cfg_b.threshold[7:0]};
      `OFS_B_THR_HIGH:      next_rdata = {24'h0, cfg_b.above, 3'h0, cfg_b.threshold[11:8]};
      `OFS_PERIODIC_CTRL:
        next_rdata = {24'h0, interval_sel, cfg_b.shutdown, cfg_a.shutdown, cfg_b.enable, cfg_a.enable};
      `OFS_A_RES_LOW:       next_rdata = {24'h0, result_a[7:0]};
      `OFS_A_RES_HIGH:      next_rdata = {28'h0, result_a[11:8]};
      `OFS_B_RES_LOW:       next_rdata = {24'h0, result_b[7:0]};
      `OFS_B_RES_HIGH:      next_rdata = {28'h0, result_b[11:8]};
      `OFS_STATUS:
        next_rdata = {20'h0, auto_pending, crossed_b, crossed_a, job.channel, single_pending, state};
      default:
        if (HADDR[7:0] >= `OFS_CAL_FIRST && HADDR[7:0] <= `OFS_CAL_LAST && HADDR[1:0] == 2'b00)
          next_rdata = {24'h0, CAL_ERRORS[3'(HADDR[7:2] - 6'(`OFS_CAL_FIRST >> 2))]}; // RULE21
    endcase
  end

endmodule : adc_conversion_sequencer
`default_nettype wire

/* adc_seq_map.svh */
// Purpose: Offsets, fields, reset values and timing counts of the conversion sequencer
// Assumes: 10 MHz MCLK, 32-bit AHB-Lite word registers
// Notes:   Definitions only
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH
`define OFS_SINGLE_SELECT    8'h00
`define OFS_SINGLE_RES_LOW   8'h04
`define OFS_SINGLE_RES_HIGH  8'h08
`define OFS_PERIODIC_SELECT  8'h0C
`define OFS_A_THR_LOW        8'h10
`define OFS_A_THR_HIGH       8'h14
`define OFS_B_THR_LOW        8'h18
`define OFS_B_THR_HIGH       8'h1C
`define OFS_PERIODIC_CTRL    8'h20
`define OFS_A_RES_LOW        8'h24
`define OFS_A_RES_HIGH       8'h28
`define OFS_B_RES_LOW        8'h2C
`define OFS_B_RES_HIGH       8'h30
`define OFS_STATUS           8'h34
`define OFS_CAL_FIRST        8'h38
`define OFS_CAL_LAST         8'h4C
`define POS_SINGLE_REQ       4
`define POS_SLOT_B_CH        4
`define POS_THR_ABOVE        7
`define POS_A_EN             0
`define POS_B_EN             1
`define POS_A_SHDN           2
`define POS_B_SHDN           3
`define POS_INTERVAL         4
`define RST_CHANNEL          3'h0
`define RST_THRESHOLD        12'hFFF
`define RST_INTERVAL         4'h0
`define CAL_REF_LOW          12'd2064
`define CAL_REF_HIGH         12'd3112
`define MCLK_HZ              10000000
`define CONV_CLK_HZ          2500000
`define CONV_HALF_CYC        (`MCLK_HZ / (2 * `CONV_CLK_HZ))
`define PWRUP_NS             10000
`define PWRUP_CYC            ((`PWRUP_NS * (`MCLK_HZ / 1000000) + 999) / 1000)
`define INTERVAL_BASE_US     1000
`define INTERVAL_BASE_CYC    (`INTERVAL_BASE_US * (`MCLK_HZ / 1000000))
`endif

/* adc_seq_pkg.sv */
// Purpose: Types of the conversion sequencer
// Assumes: Nothing beyond SystemVerilog packages
// Notes:   Constants live in adc_seq_map.svh
`default_nettype none
package adc_seq_pkg;
  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0001,
    ST_POWER_UP = 4'b0010,
    ST_CONVERT  = 4'b0100,
    ST_WAIT     = 4'b1000
  } state_t;
  typedef struct packed {
    logic [2:0]  channel;
    logic [11:0] threshold;
    logic        above;
    logic        enable;
    logic        shutdown;
  } slot_cfg_t;
  typedef struct packed {
    logic       single;
    logic       dest_b;
    logic [2:0] channel;
  } job_t;
endpackage : adc_seq_pkg
`default_nettype wire

/* adc_seq_asserts.sv */
// Purpose: Checker of the sequencer outputs at the top ports
// Assumes: Bound into adc_conversion_sequencer
// Notes:   Pulses, converter power and clock timing
`default_nettype none
module adc_seq_asserts (
  input wire logic       MCLK,            // Clock
  input wire logic       RST,             // Sync reset
  input wire logic       HREADYOUT,       // Slave ready
  input wire logic       HRESP,           // Response
  input wire logic       CONV_CLK,        // Modulator clock
  input wire logic       CONV_POWER,      // Converter power
  input wire logic       CONV_START,      // Start pulse
  input wire logic [2:0] CONV_CHANNEL,    // Mux select
  input wire logic       SINGLE_DONE_IRQ, // Single done
  input wire logic       THRESH_IRQ,      // Threshold crossed
  input wire logic       SHUTDOWN_REQ     // Shutdown request
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  bus_okay_a: assert property (HREADYOUT && !HRESP) else $error("bus not ready or not okay");
  start_powered_a: assert property (CONV_START |-> CONV_POWER) else $error("start without power");
  settle_time_a: assert property ($rose(CONV_POWER) |-> ##[99:101] CONV_START) else $error("start not after settle");
  clk_idle_a: assert property (!CONV_POWER && !$past(CONV_POWER) |-> !CONV_CLK) else $error("clock while off");
  clk_rate_a: assert property ($rose(CONV_CLK) |-> ##2 !CONV_CLK) else $error("clock high time wrong");
  one_conv_a: assert property (CONV_START |=> !CONV_START [*8]) else $error("starts too close");
  chan_hold_a: assert property (CONV_START |=> $stable(CONV_CHANNEL) [*4]) else $error("channel moved");
  single_pulse_a: assert property (SINGLE_DONE_IRQ |=> !SINGLE_DONE_IRQ) else $error("single irq not a pulse");
  thr_pulse_a: assert property (THRESH_IRQ |=> !THRESH_IRQ) else $error("threshold irq not a pulse");
  shdn_cause_a: assert property (SHUTDOWN_REQ |-> THRESH_IRQ) else $error("shutdown without crossing");
  single_c: cover property (SINGLE_DONE_IRQ);
  thr_c: cover property (THRESH_IRQ);
  shdn_c: cover property (SHUTDOWN_REQ);
endmodule : adc_seq_asserts
bind adc_conversion_sequencer adc_seq_asserts u_chk (
  .MCLK(MCLK), .RST(RST), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CONV_CLK(CONV_CLK),
  .CONV_POWER(CONV_POWER), .CONV_START(CONV_START), .CONV_CHANNEL(CONV_CHANNEL),
  .SINGLE_DONE_IRQ(SINGLE_DONE_IRQ), .THRESH_IRQ(THRESH_IRQ), .SHUTDOWN_REQ(SHUTDOWN_REQ)
);
`default_nettype wire

/* conv_core_model.sv */
// Purpose: Behavioural converter core answering start pulses
// Assumes: One conversion at a time
// Notes:   Released data shows the inverse of the last code
`default_nettype none
module conv_core_model (
  input  wire logic             clk,     // System clock
  input  wire logic             start,   // Start pulse
  input  wire logic [2:0]       channel, // Mux select
  input  wire logic             power,   // Converter power
  input  wire logic             slow,    // Long conversion
  input  wire logic [7:0][11:0] codes,   // Code per channel
  output var  logic             done,    // Result ready
  output var  logic [11:0]      data     // Result code
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       busy = 1'b0;
  logic [5:0] cnt  = 6'h00;
  logic [2:0] ch   = 3'h0;
  initial done = 1'b0;
  initial data = 12'h0;
  always @(posedge clk)
  begin
    if (start && power)
    begin
      busy <= 1'b1;
      ch <= channel;
      cnt <= slow ? 6'h28 : 6'h06;
    end
    else if (busy && cnt != 6'h00)
      cnt <= cnt - 6'h01;
    else if (busy)
    begin
      busy <= 1'b0;
      done <= 1'b1;
      data <= codes[ch];
    end
    else if (done && !power)
    begin
      done <= 1'b0;
      data <= ~data;
    end
  end
endmodule : conv_core_model
`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench of the conversion sequencer
// Assumes: Zero wait state AHB-Lite slave, short interval base
// Notes:   Random codes from a fixed seed
`include "adc_seq_map.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [47:0] CAL = 48'hA1B2C3D4E5F6;
  logic             MCLK, RST, HSEL, HWRITE, slow, SLEEP_STATE, OFF_STATE, THERMAL_EN;
  logic [1:0]       HTRANS;
  logic [31:0]      HADDR, HWDATA, seed;
  logic [7:0][11:0] codes;
  logic [11:0]      last;
  logic [5:0]       sc;
  wire logic [31:0] HRDATA;
  wire logic [11:0] CONV_DATA;
  wire logic [2:0]  CONV_CHANNEL;
  wire logic        HREADYOUT, HRESP, CONV_CLK, CONV_POWER, CONV_START, CONV_DONE;
  wire logic        SINGLE_DONE_IRQ, THRESH_IRQ, SHUTDOWN_REQ;
  int               fails, n_compared, n_single, n_thr, n_sd;
  adc_conversion_sequencer #(.INTERVAL_BASE_CYCLES(24'd20), .CAL_ERRORS(CAL)) dut (
    .MCLK(MCLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .CONV_CLK(CONV_CLK), .CONV_POWER(CONV_POWER), .CONV_START(CONV_START),
    .CONV_CHANNEL(CONV_CHANNEL), .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA),
    .SLEEP_STATE(SLEEP_STATE), .OFF_STATE(OFF_STATE), .THERMAL_EN(THERMAL_EN),
    .SINGLE_DONE_IRQ(SINGLE_DONE_IRQ), .THRESH_IRQ(THRESH_IRQ), .SHUTDOWN_REQ(SHUTDOWN_REQ));
  conv_core_model core (.clk(MCLK), .start(CONV_START), .channel(CONV_CHANNEL), .power(CONV_POWER),
    .slow(slow), .codes(codes), .done(CONV_DONE), .data(CONV_DATA));
  always #50 MCLK = ~MCLK;
  always @(negedge MCLK)
  begin
    n_single += int'(SINGLE_DONE_IRQ === 1'b1);
    n_thr += int'(THRESH_IRQ === 1'b1);
    n_sd += int'(SHUTDOWN_REQ === 1'b1);
  end
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic phase(output logic [31:0] q);
    int   n;
    logic r;
    n = 0;
    do
    begin
      @(posedge MCLK);
      q = HRDATA;
      r = HREADYOUT;
      n++;
    end
    while (r !== 1'b1 && n < 50);
    if (r !== 1'b1)
    begin
      fails++;
      stop_test();
    end
  endtask : phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge MCLK);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    phase(q);
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= d;
    phase(q);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(what, q, exp);
  endtask : rd_chk
  function automatic logic allowed(input logic [5:0] s);
    return !(s[5] || s[4]) || s[2:0] <= 3'h4 || (s[2:0] inside {3'h5, 3'h6} && s[5] && !s[4] && s[3]);
  endfunction : allowed
  task automatic single(input logic [2:0] ch, input logic go);
    int k;
    int base;
    base = n_single;
    k = 0;
    wr(`OFS_SINGLE_SELECT, {29'h0, ch});
    wr(`OFS_SINGLE_SELECT, {27'h0, 1'b1, 1'b0, ch});
    while (n_single == base && k < 2000)
    begin
      @(posedge MCLK);
      k++;
    end
    check("single irq", {31'h0, n_single != base}, {31'h0, go});
    if (go && n_single == base)
      stop_test();
    if (go)
    begin
      last = codes[ch];
      rd_chk("single low", `OFS_SINGLE_RES_LOW, {24'h0, last[7:0]});
      rd_chk("single high", `OFS_SINGLE_RES_HIGH, {28'h0, last[11:8]});
    end
  endtask : single
  task automatic periodic;
    int k;
    int t0;
    int s0;
    k = 0;
    t0 = n_thr;
    s0 = n_sd;
    slow <= 1'($urandom);
    codes[1] = codes[1] | 12'h001;
    codes[6] = codes[6] & 12'h7FF;
    wr(`OFS_PERIODIC_SELECT, 32'h16);
    wr(`OFS_A_THR_LOW, 32'h00);
    wr(`OFS_A_THR_HIGH, 32'h80);
    wr(`OFS_B_THR_LOW, 32'hFF);
    wr(`OFS_B_THR_HIGH, 32'h0F);
    wr(`OFS_PERIODIC_CTRL, 32'h07);
    single(3'h4, 1'b1);
    while (n_thr - t0 < 6 && k < 6000)
    begin
      @(posedge MCLK);
      k++;
    end
    check("crossings", {31'h0, k < 6000}, 32'h1);
    check("shutdowns", {31'h0, n_sd > s0 && n_sd - s0 < n_thr - t0}, 32'h1);
    wr(`OFS_PERIODIC_CTRL, 32'h00);
    k = 0;
    while (CONV_POWER !== 1'b0 && k < 500)
    begin
      @(posedge MCLK);
      k++;
    end
    check("power off", {31'h0, CONV_POWER}, 32'h0);
    rd_chk("a low", `OFS_A_RES_LOW, {24'h0, codes[1][7:0]});
    rd_chk("a high", `OFS_A_RES_HIGH, {28'h0, codes[1][11:8]});
    rd_chk("b low", `OFS_B_RES_LOW, {24'h0, codes[6][7:0]});
    rd_chk("b high", `OFS_B_RES_HIGH, {28'h0, codes[6][11:8]});
  endtask : periodic
  initial
  begin
    {MCLK, HSEL, HWRITE, slow, SLEEP_STATE, OFF_STATE} = 6'h00;
    {RST, THERMAL_EN} = 2'b11;
    {HTRANS, HADDR, HWDATA} = '0;
    {fails, n_compared, n_single, n_thr, n_sd} = '0;
    seed = $urandom(39530);
    for (int i = 0; i < 8; i++)
      codes[i] = 12'($urandom);
    codes[0] = 12'h000;
    codes[7] = 12'hFFF;
    repeat (8) @(posedge MCLK);
    RST <= 1'b0;
    rd_chk("thr low", `OFS_A_THR_LOW, 32'hFF);
    rd_chk("thr high", `OFS_B_THR_HIGH, 32'h8F);
    rd_chk("ctrl", `OFS_PERIODIC_CTRL, 32'h00);
    rd_chk("unmapped", 8'h80, 32'h00);
    wr(`OFS_CAL_FIRST, 32'h55);
    for (int i = 0; i < 6; i++)
      rd_chk("cal", 8'(`OFS_CAL_FIRST + 4 * i), {24'h0, CAL[8 * i +: 8]});
    wr(`OFS_SINGLE_SELECT, 32'h10);
    repeat (300) @(posedge MCLK);
    for (int i = 0; i < 8; i++)
      single(3'(i), 1'b1);
    periodic();
    for (int i = 0; i < 8; i++)
      codes[i] = 12'($urandom);
    periodic();
    rd_chk("single hold", `OFS_SINGLE_RES_LOW, {24'h0, last[7:0]});
    for (int i = 0; i < 10; i++)
    begin
      sc = (i < 4) ? 6'(32'h2D261F24 >> (8 * (3 - i))) : 6'($urandom);
      SLEEP_STATE <= sc[5];
      OFF_STATE <= sc[4];
      THERMAL_EN <= sc[3];
      repeat (10) @(posedge MCLK);
      single(sc[2:0], allowed(sc));
    end
    stop_test();
  end
  initial
  begin
    repeat (95000) @(posedge MCLK);
    fails++;
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
